/* File: verilog/isa_device_end.sv */
// Device end of the ISA slave port
`timescale 1ns/10ps
`include "isa_params.svh"
module isa_device_end
    import isa_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    isa_bus_if.dev bus,
    input wire logic [`IO_HI-`IO_LO:0] io_base,
    input wire logic [`ADDR_W-1-`MEM_LO:0] mem_base,
    input wire logic [`IRQ_SEL_W-1:0] irq_sel,
    input wire logic irq_req,
    output logic acc_valid,
    output kind_e acc_kind,
    output addr_t acc_addr,
    output logic [1:0] acc_be,
    output data_t acc_wdata,
    input wire logic acc_done,
    input wire data_t acc_rdata,
    output logic sys16
);
    typedef enum {ST_IDLE, ST_WAIT, ST_DRIVE} dev_state_e;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [`DEV_SYNC_W-1:0] sync_q;
    logic s_bale;
    logic s_aen;
    logic s_smemr_n;
    logic s_smemw_n;
    logic s_memr_n;
    logic s_memw_n;
    logic s_ior_n;
    logic s_iow_n;
    logic s_sbhe_n;
    addr_t s_sa;
    data_t s_sd;

    // All bus pins pass two flops, reset to their idle levels
    bit_sync #(
        .WIDTH(`DEV_SYNC_W),
        .RST_VAL(`DEV_SYNC_RST)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .din({bus.bale, bus.aen, bus.smemr_n, bus.smemw_n, bus.memr_n, bus.memw_n,
              bus.ior_n, bus.iow_n, bus.sbhe_n, bus.sa, bus.sd}),
        .dout(sync_q)
    );

    assign {s_bale, s_aen, s_smemr_n, s_smemw_n, s_memr_n, s_memw_n,
            s_ior_n, s_iow_n, s_sbhe_n, s_sa, s_sd} = sync_q;

    // ****************************************
    // State
    // ****************************************
    dev_state_e state_reg;
    dev_state_e state_next;
    logic bale_d_reg;
    logic cmd_d_reg;
    logic cmd_d_next;
    addr_t addr_reg;
    addr_t addr_next;
    logic addr_ok_reg;
    logic addr_ok_next;
    kind_e kind_reg;
    kind_e kind_next;
    logic [1:0] be_reg;
    logic [1:0] be_next;
    data_t wdata_reg;
    data_t wdata_next;
    data_t rdata_reg;
    data_t rdata_next;
    logic acc_valid_reg;
    logic acc_valid_next;
    logic chrdy_oe_n_reg;
    logic chrdy_oe_n_next;
    logic [1:0] sd_oe_n_reg;
    logic [1:0] sd_oe_n_next;
    logic io16_oe_n_reg;
    logic io16_oe_n_next;
    logic sys16_reg;
    logic sys16_next;
    logic [`IRQ_N-1:0] irq_out_reg;
    logic [`IRQ_N-1:0] irq_out_next;
    logic [`IRQ_N-1:0] irq_oe_n_reg;
    logic [`IRQ_N-1:0] irq_oe_n_next;

    // ****************************************
    // Cycle decode
    // ****************************************
    logic below_1m;
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic cmd_any;
    logic io_hit;
    logic mem_hit;
    logic hit;
    logic be_hi;
    logic [`IRQ_SEL_W-1:0] irq_pick;
    kind_e kind_c;

    // System memory strobes qualified by address range
    assign below_1m = addr_reg[`ADDR_W-1:`MB_LO] == '0;
    assign mem_rd = !s_memr_n || (!s_smemr_n && below_1m);
    assign mem_wr = !s_memw_n || (!s_smemw_n && below_1m);
    assign io_rd = !s_ior_n;
    assign io_wr = !s_iow_n;
    // No command is seen during a DMA cycle
    assign cmd_any = !s_aen && (io_rd || io_wr || mem_rd || mem_wr);
    // Window hits on the latched address
    assign io_hit = addr_ok_reg && (addr_reg[`IO_HI:`IO_LO] == io_base);
    assign mem_hit = addr_ok_reg && (addr_reg[`ADDR_W-1:`MEM_LO] == mem_base);
    assign hit = (io_rd || io_wr) ? io_hit : mem_hit;
    // Upper lane only in a 16-bit system
    assign be_hi = sys16_reg && !s_sbhe_n;
    assign irq_pick = (irq_sel > `IRQ_MAX) ? `IRQ_MAX : irq_sel;

    // Access kind from the active strobe
    always_comb
    begin
        kind_c = KIND_MEM_WR;
        if (io_rd)
            kind_c = KIND_IO_RD;
        else if (io_wr)
            kind_c = KIND_IO_WR;
        else if (mem_rd)
            kind_c = KIND_MEM_RD;
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        cmd_d_next = cmd_any;
        addr_next = addr_reg;
        addr_ok_next = addr_ok_reg;
        kind_next = kind_reg;
        be_next = be_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        acc_valid_next = 1'b0;
        chrdy_oe_n_next = chrdy_oe_n_reg;
        sd_oe_n_next = sd_oe_n_reg;
        // Full memory read seen low means 16-bit slot
        sys16_next = sys16_reg || !s_memr_n;
        // Address taken at latch enable fall
        if (bale_d_reg && !s_bale)
        begin
            addr_next = s_sa;
            addr_ok_next = !s_aen;
        end
        else if ((cmd_d_reg && !cmd_any) || s_aen)
            addr_ok_next = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                // Start once the latched address is valid
                if (cmd_any && hit)
                begin
                    kind_next = kind_c;
                    be_next = {be_hi, !addr_reg[0] || !be_hi};
                    wdata_next = s_sd;
                    acc_valid_next = 1'b1;
                    chrdy_oe_n_next = 1'b0;
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (!cmd_any)
                begin
                    chrdy_oe_n_next = 1'b1;
                    state_next = ST_IDLE;
                end
                else if (acc_done)
                begin
                    rdata_next = acc_rdata;
                    chrdy_oe_n_next = 1'b1;
                    if (kind_reg == KIND_IO_RD || kind_reg == KIND_MEM_RD)
                        sd_oe_n_next = ~be_reg;
                    state_next = ST_DRIVE;
                end
            end
            ST_DRIVE:
            begin
                if (!cmd_any)
                begin
                    sd_oe_n_next = 2'b11;
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                chrdy_oe_n_next = 1'b1;
                sd_oe_n_next = 2'b11;
                state_next = ST_IDLE;
            end
        endcase
        // Wide IO indication for own IO window only
        io16_oe_n_next = !(io_hit && !s_aen && !mem_rd && !mem_wr);
    end

    // Interrupt pins: one driven, rest floating
    generate
        for (genvar i = 0; i < `IRQ_N; i++)
        begin : g_irq
            assign irq_oe_n_next[i] = irq_pick != `IRQ_SEL_W'(i);
            assign irq_out_next[i] = irq_req;
        end
    endgenerate

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            bale_d_reg <= 1'b0;
            cmd_d_reg <= 1'b0;
            addr_reg <= '0;
            addr_ok_reg <= 1'b0;
            kind_reg <= KIND_IO_RD;
            be_reg <= 2'h0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            acc_valid_reg <= 1'b0;
            chrdy_oe_n_reg <= 1'b1;
            sd_oe_n_reg <= 2'h3;
            io16_oe_n_reg <= 1'b1;
            sys16_reg <= 1'b0;
            irq_out_reg <= '0;
            irq_oe_n_reg <= '1;
        end
        else
        begin
            state_reg <= state_next;
            bale_d_reg <= s_bale;
            cmd_d_reg <= cmd_d_next;
            addr_reg <= addr_next;
            addr_ok_reg <= addr_ok_next;
            kind_reg <= kind_next;
            be_reg <= be_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            acc_valid_reg <= acc_valid_next;
            chrdy_oe_n_reg <= chrdy_oe_n_next;
            sd_oe_n_reg <= sd_oe_n_next;
            io16_oe_n_reg <= io16_oe_n_next;
            sys16_reg <= sys16_next;
            irq_out_reg <= irq_out_next;
            irq_oe_n_reg <= irq_oe_n_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bus.dev_sd_out = rdata_reg;
    assign bus.dev_sd_oe_n = sd_oe_n_reg;
    assign bus.io16_out = 1'b0;
    assign bus.io16_oe_n = io16_oe_n_reg;
    assign bus.chrdy_out = 1'b0;
    assign bus.chrdy_oe_n = chrdy_oe_n_reg;
    assign bus.irq_out = irq_out_reg;
    assign bus.irq_oe_n = irq_oe_n_reg;
    assign acc_valid = acc_valid_reg;
    assign acc_kind = kind_reg;
    assign acc_addr = addr_reg;
    assign acc_be = be_reg;
    assign acc_wdata = wdata_reg;
    assign sys16 = sys16_reg;
endmodule

/* File: verilog/isa_params.svh */
// Constants for the ISA slave port pair
`ifndef ISA_PARAMS_SVH
`define ISA_PARAMS_SVH
`define ADDR_W 24
`define DATA_W 16
`define IRQ_N 5
`define IRQ_SEL_W 3
`define IRQ_MAX 3'h4
`define MB_LO 20
`define IO_HI 15
`define IO_LO 4
`define MEM_LO 14
`define CNT_W 5
`define CLK_NS 8
`define BALE_NS 60
`define CMD_NS 120
`define RECOV_NS 80
`define BALE_CYC ((`BALE_NS + `CLK_NS - 1) / `CLK_NS)
`define CMD_CYC ((`CMD_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOV_CYC ((`RECOV_NS + `CLK_NS - 1) / `CLK_NS)
`define DEV_SYNC_W 49
`define DEV_SYNC_RST 49'h7f000000ffff
`define HOST_SYNC_W 23
`define HOST_SYNC_RST 23'h7fffe0
`define SD_IDLE 16'hffff
`define STB_SMEMR 0
`define STB_SMEMW 1
`define STB_MEMR 2
`define STB_MEMW 3
`define STB_IOR 4
`define STB_IOW 5
`define STB_W 6
`endif

/* File: verilog/isa_pkg.sv */
// Types shared by the ISA slave port ends
`include "isa_params.svh"
package isa_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef enum logic [1:0] {KIND_IO_RD, KIND_IO_WR, KIND_MEM_RD, KIND_MEM_WR} kind_e;
endpackage

/* File: verilog/isa_bus_if.sv */
// ISA bus wires between host end and device end
`timescale 1ns/10ps
`include "isa_params.svh"
interface isa_bus_if;
    import isa_pkg::*;
    addr_t sa;
    logic bale;
    logic aen;
    logic smemr_n;
    logic smemw_n;
    logic memr_n;
    logic memw_n;
    logic ior_n;
    logic iow_n;
    logic sbhe_n;
    data_t host_sd_out;
    logic host_sd_oe_n;
    data_t dev_sd_out;
    logic [1:0] dev_sd_oe_n;
    data_t sd;
    logic io16_out;
    logic io16_oe_n;
    logic io16_n;
    logic chrdy_out;
    logic chrdy_oe_n;
    logic chrdy;
    logic [`IRQ_N-1:0] irq_out;
    logic [`IRQ_N-1:0] irq_oe_n;
    logic [`IRQ_N-1:0] irq;

    // ****************************************
    // Wire levels from drivers and pulls
    // ****************************************
    // Data lanes: device per byte, else host, else pulled high
    assign sd[7:0] = !dev_sd_oe_n[0] ? dev_sd_out[7:0] : (!host_sd_oe_n ? host_sd_out[7:0] : 8'hff);
    assign sd[15:8] = !dev_sd_oe_n[1] ? dev_sd_out[15:8] : (!host_sd_oe_n ? host_sd_out[15:8] : 8'hff);
    // Open-drain lines with pull-ups
    assign io16_n = io16_oe_n ? 1'b1 : io16_out;
    assign chrdy = chrdy_oe_n ? 1'b1 : chrdy_out;
    // Interrupt pins pulled low when floating
    assign irq = irq_out & ~irq_oe_n;

    modport dev (
        input sa, bale, aen, smemr_n, smemw_n, memr_n, memw_n, ior_n, iow_n, sbhe_n, sd,
        output dev_sd_out, dev_sd_oe_n, io16_out, io16_oe_n, chrdy_out, chrdy_oe_n, irq_out, irq_oe_n
    );
    modport host (
        output sa, bale, aen, smemr_n, smemw_n, memr_n, memw_n, ior_n, iow_n, sbhe_n,
        output host_sd_out, host_sd_oe_n,
        input sd, io16_n, chrdy, irq
    );
endinterface

/* File: verilog/bit_sync.sv */
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule

/* File: verilog/isa_host_end.sv */
// Host end of the ISA slave port
`timescale 1ns/10ps
`include "isa_params.svh"
module isa_host_end
    import isa_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    isa_bus_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire kind_e cmd_kind,
    input wire addr_t cmd_addr,
    input wire data_t cmd_wdata,
    input wire logic cmd_wide,
    input wire logic cmd_dma,
    output logic rsp_valid,
    output data_t rsp_rdata,
    output logic rsp_io16,
    output logic [`IRQ_N-1:0] irq_level
);
    typedef enum {H_IDLE, H_ADDR, H_CMD, H_RECOV} host_state_e;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [`HOST_SYNC_W-1:0] sync_q;
    logic s_chrdy;
    logic s_io16_n;
    data_t s_sd;
    logic [`IRQ_N-1:0] s_irq;

    bit_sync #(
        .WIDTH(`HOST_SYNC_W),
        .RST_VAL(`HOST_SYNC_RST)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .din({bus.chrdy, bus.io16_n, bus.sd, bus.irq}),
        .dout(sync_q)
    );

    assign {s_chrdy, s_io16_n, s_sd, s_irq} = sync_q;

    // ****************************************
    // State
    // ****************************************
    host_state_e state_reg;
    host_state_e state_next;
    logic [`CNT_W-1:0] cnt_reg;
    logic [`CNT_W-1:0] cnt_next;
    addr_t addr_reg;
    addr_t addr_next;
    data_t wdata_reg;
    data_t wdata_next;
    kind_e kind_reg;
    kind_e kind_next;
    logic bale_reg;
    logic bale_next;
    logic aen_reg;
    logic aen_next;
    logic sbhe_n_reg;
    logic sbhe_n_next;
    logic sd_oe_n_reg;
    logic sd_oe_n_next;
    logic [`STB_W-1:0] stb_n_reg;
    logic [`STB_W-1:0] stb_n_next;
    logic io16_seen_reg;
    logic io16_seen_next;
    logic rsp_valid_reg;
    logic rsp_valid_next;
    data_t rsp_rdata_reg;
    data_t rsp_rdata_next;
    logic rsp_io16_reg;
    logic rsp_io16_next;
    logic low_mem;

    assign low_mem = addr_reg[`ADDR_W-1:`MB_LO] == '0;
    assign cmd_ready = state_reg == H_IDLE;

    // ****************************************
    // Cycle sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        kind_next = kind_reg;
        bale_next = bale_reg;
        aen_next = aen_reg;
        sbhe_n_next = sbhe_n_reg;
        sd_oe_n_next = sd_oe_n_reg;
        stb_n_next = stb_n_reg;
        io16_seen_next = io16_seen_reg;
        rsp_valid_next = 1'b0;
        rsp_rdata_next = rsp_rdata_reg;
        rsp_io16_next = rsp_io16_reg;
        case (state_reg)
            H_IDLE:
            begin
                if (cmd_valid)
                begin
                    addr_next = cmd_addr;
                    wdata_next = cmd_wdata;
                    kind_next = cmd_kind;
                    aen_next = cmd_dma;
                    sbhe_n_next = !cmd_wide;
                    sd_oe_n_next = !(cmd_kind == KIND_IO_WR || cmd_kind == KIND_MEM_WR);
                    bale_next = 1'b1;
                    io16_seen_next = 1'b0;
                    cnt_next = `CNT_W'(`BALE_CYC - 1);
                    state_next = H_ADDR;
                end
            end
            H_ADDR:
            begin
                if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else
                begin
                    bale_next = 1'b0;
                    stb_n_next[`STB_IOR] = kind_reg != KIND_IO_RD;
                    stb_n_next[`STB_IOW] = kind_reg != KIND_IO_WR;
                    stb_n_next[`STB_MEMR] = kind_reg != KIND_MEM_RD;
                    stb_n_next[`STB_MEMW] = kind_reg != KIND_MEM_WR;
                    stb_n_next[`STB_SMEMR] = !(kind_reg == KIND_MEM_RD && low_mem);
                    stb_n_next[`STB_SMEMW] = !(kind_reg == KIND_MEM_WR && low_mem);
                    cnt_next = `CNT_W'(`CMD_CYC - 1);
                    state_next = H_CMD;
                end
            end
            H_CMD:
            begin
                io16_seen_next = io16_seen_reg || !s_io16_n;
                if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else if (s_chrdy)
                begin
                    stb_n_next = '1;
                    sd_oe_n_next = 1'b1;
                    rsp_valid_next = 1'b1;
                    rsp_rdata_next = s_sd;
                    rsp_io16_next = io16_seen_reg;
                    cnt_next = `CNT_W'(`RECOV_CYC - 1);
                    state_next = H_RECOV;
                end
            end
            H_RECOV:
            begin
                aen_next = 1'b0;
                sbhe_n_next = 1'b1;
                if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else
                    state_next = H_IDLE;
            end
            default:
            begin
                stb_n_next = '1;
                state_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= H_IDLE;
            cnt_reg <= '0;
            addr_reg <= '0;
            wdata_reg <= '0;
            kind_reg <= KIND_IO_RD;
            bale_reg <= 1'b0;
            aen_reg <= 1'b0;
            sbhe_n_reg <= 1'b1;
            sd_oe_n_reg <= 1'b1;
            stb_n_reg <= '1;
            io16_seen_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= '0;
            rsp_io16_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            kind_reg <= kind_next;
            bale_reg <= bale_next;
            aen_reg <= aen_next;
            sbhe_n_reg <= sbhe_n_next;
            sd_oe_n_reg <= sd_oe_n_next;
            stb_n_reg <= stb_n_next;
            io16_seen_reg <= io16_seen_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_rdata_reg <= rsp_rdata_next;
            rsp_io16_reg <= rsp_io16_next;
        end
    end

    // Bus pins and user outputs
    assign bus.sa = addr_reg;
    assign bus.bale = bale_reg;
    assign bus.aen = aen_reg;
    assign bus.sbhe_n = sbhe_n_reg;
    assign bus.smemr_n = stb_n_reg[`STB_SMEMR];
    assign bus.smemw_n = stb_n_reg[`STB_SMEMW];
    assign bus.memr_n = stb_n_reg[`STB_MEMR];
    assign bus.memw_n = stb_n_reg[`STB_MEMW];
    assign bus.ior_n = stb_n_reg[`STB_IOR];
    assign bus.iow_n = stb_n_reg[`STB_IOW];
    assign bus.host_sd_out = wdata_reg;
    assign bus.host_sd_oe_n = sd_oe_n_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign rsp_io16 = rsp_io16_reg;
    assign irq_level = s_irq;
endmodule

/* File: sim/isa_port_checker_sva.sv */
// Concurrent checks on the ISA wires between host end and device end
`timescale 1ns/10ps
`include "isa_params.svh"
module isa_port_checker
    import isa_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire addr_t sa,
    input wire logic bale,
    input wire logic aen,
    input wire logic smemr_n,
    input wire logic smemw_n,
    input wire logic memr_n,
    input wire logic memw_n,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic sbhe_n,
    input wire logic host_sd_oe_n,
    input wire logic [1:0] dev_sd_oe_n,
    input wire logic io16_n,
    input wire logic chrdy,
    input wire logic [`IRQ_N-1:0] irq_oe_n
);
    logic act;
    // Any IO or full memory command strobe active
    assign act = !ior_n || !iow_n || !memr_n || !memw_n;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // ****************************************
    // Wire relations
    // ****************************************
    a_dma_no_data: assert property (aen |-> dev_sd_oe_n == 2'b11)
        else $error("data driven in dma cycle");
    a_dma_no_io16: assert property (aen && $past(aen, 4) |-> io16_n)
        else $error("io16 pulled in dma cycle");
    a_latch_before_cmd: assert property (bale |-> !act)
        else $error("command strobe while latch enable high");
    a_smem_low_only: assert property (!smemr_n || !smemw_n |-> sa[23:20] == 4'h0)
        else $error("system strobe above 1 mbyte");
    a_smem_with_full: assert property ($fell(smemr_n) |-> !memr_n)
        else $error("full read strobe missing");
    a_ready_in_cmd: assert property ($fell(chrdy) |-> act)
        else $error("ready pulled outside command");
    a_host_holds: assert property (!chrdy && act |=> act)
        else $error("command ended while not ready");
    a_ready_bound: assert property ($fell(chrdy) |-> ##[1:80] chrdy)
        else $error("ready held low too long");
    a_irq_one_pin: assert property ($past(rstn) |-> $onehot(~irq_oe_n))
        else $error("interrupt pin selection not single");
    a_no_contention: assert property (!(dev_sd_oe_n != 2'b11 && !host_sd_oe_n))
        else $error("both ends drive data");
    a_high_lane: assert property ($fell(dev_sd_oe_n[1]) |-> !sbhe_n)
        else $error("high lane without high enable");
    // Main scenarios
    c_stretch: cover property ($fell(chrdy));
    c_io16: cover property ($fell(io16_n));
    c_dma: cover property (aen && !ior_n);
    c_low_mem: cover property ($fell(smemr_n));
endmodule

/* File: sim/test_isa_host_bus_slave_port.sv */
// Testbench joining host end and device end of the ISA slave port
`timescale 1ns/10ps
`include "isa_params.svh"
module test_isa_host_bus_slave_port;
    import isa_pkg::*;
    logic clock = 0, rstn = 0, cmd_valid = 0, cmd_wide = 0, cmd_dma = 0, irq_req = 0, acc_done = 0;
    logic cmd_ready, rsp_valid, rsp_io16, acc_valid, sys16;
    kind_e cmd_kind = KIND_IO_RD, acc_kind;
    addr_t cmd_addr = '0, acc_addr;
    data_t cmd_wdata = 16'h1e2d, acc_rdata = 16'ha5c3, rsp_rdata, acc_wdata;
    logic [1:0] acc_be;
    logic [`IRQ_N-1:0] irq_level;
    logic [11:0] io_base = 12'h030;
    logic [9:0] mem_base = 10'h032;
    logic [2:0] irq_sel = 3'h0;
    int mismatches = 0, n_checks = 0, hits = 0, stall = 2, lat;
    isa_bus_if bus();
    isa_host_end i_isa_host_end (.clock, .rstn, .bus(bus), .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr,
        .cmd_wdata, .cmd_wide, .cmd_dma, .rsp_valid, .rsp_rdata, .rsp_io16, .irq_level);
    isa_device_end i_isa_device_end (.clock, .rstn, .bus(bus), .io_base, .mem_base, .irq_sel, .irq_req,
        .acc_valid, .acc_kind, .acc_addr, .acc_be, .acc_wdata, .acc_done, .acc_rdata, .sys16);
    isa_port_checker i_isa_port_checker (.clock, .rstn, .sa(bus.sa), .bale(bus.bale), .aen(bus.aen),
        .smemr_n(bus.smemr_n), .smemw_n(bus.smemw_n), .memr_n(bus.memr_n), .memw_n(bus.memw_n),
        .ior_n(bus.ior_n), .iow_n(bus.iow_n), .sbhe_n(bus.sbhe_n), .host_sd_oe_n(bus.host_sd_oe_n),
        .dev_sd_oe_n(bus.dev_sd_oe_n), .io16_n(bus.io16_n), .chrdy(bus.chrdy), .irq_oe_n(bus.irq_oe_n));
    // ****************************************
    // Clock, responder and tasks
    // ****************************************
    always #4 clock = ~clock;
    // Device user side answers each access after a stall
    always @(posedge clock)
    begin
        if (acc_valid === 1'b1)
        begin
            hits++;
            repeat (stall) @(posedge clock);
            #1 acc_done = 1;
            @(posedge clock);
            #1 acc_done = 0;
        end
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One host command, waiting for the response
    task automatic run(input kind_e k, input addr_t a, input logic w, input logic d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            #1 n++;
        end
        cmd_kind = k;
        cmd_addr = a;
        cmd_wide = w;
        cmd_dma = d;
        cmd_valid = 1;
        @(posedge clock);
        #1 cmd_valid = 0;
        lat = 0;
        while (rsp_valid !== 1'b1 && lat < 400)
        begin
            @(posedge clock);
            #1 lat++;
        end
        check(lat < 400, 1);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        repeat (6) @(posedge clock);
        #1 rstn = 1;
        check(sys16, 0);
        run(KIND_MEM_RD, 24'h0c8010, 1, 0);
        check(sys16, 1);
        check(hits, 1);
        check(acc_addr, 24'h0c8010);
        check(rsp_rdata, 16'ha5c3);
        check(rsp_io16, 0);
        run(KIND_IO_WR, 24'h000302, 1, 0);
        check(hits, 2);
        check(acc_kind, KIND_IO_WR);
        check({acc_be, acc_wdata}, {2'b11, 16'h1e2d});
        check(rsp_io16, 1);
        stall = 30;
        run(KIND_IO_RD, 24'h00030f, 0, 0);
        check(lat > 30, 1);
        check(acc_be, 2'b01);
        check(rsp_rdata, 16'hffc3);
        stall = 0;
        run(KIND_IO_RD, 24'h000310, 1, 0);
        check(hits, 3);
        check(rsp_io16, 0);
        check(rsp_rdata, 16'hffff);
        run(KIND_IO_RD, 24'h000300, 1, 1);
        check(hits, 3);
        check(rsp_io16, 0);
        mem_base = 10'h100;
        run(KIND_MEM_WR, 24'h400020, 1, 0);
        check(hits, 4);
        check(acc_kind, KIND_MEM_WR);
        check(acc_addr, 24'h400020);
        check(rsp_io16, 0);
        irq_req = 1;
        for (int s = 0; s < 8; s++)
        begin
            irq_sel = 3'(s);
            repeat (5) @(posedge clock);
            #1 check(irq_level, 5'h01 << (s > 4 ? 4 : s));
        end
        irq_req = 0;
        repeat (5) @(posedge clock);
        #1 check(irq_level, 5'h00);
        summarize();
    end
    // Watchdog against a hung handshake
    initial
    begin
        #200000;
        mismatches++;
        summarize();
    end
endmodule
